// File: core/ppm_pkg.sv
// constants and carrier types for the power management capability
package ppm_pkg;

  // config space dword addresses
  localparam logic [7:0] PPM_CAP_OFS = 8'h40;
  localparam logic [7:0] PPM_CSR_OFS = 8'h44;

  // capability header bytes
  localparam logic [7:0] PPM_CAP_ID   = 8'h01;
  localparam logic [7:0] PPM_NEXT_PTR = 8'h00;

  // capabilities word fields
  localparam logic [4:0] PPM_WAKE_STATES = 5'h18;
  localparam logic       PPM_MID_LOW     = 1'b0;
  localparam logic       PPM_MID_HIGH    = 1'b0;
  localparam logic [2:0] PPM_AUX_CURRENT = 3'h7;
  localparam logic       PPM_DSI         = 1'b0;
  localparam logic       PPM_CAP_RSVD    = 1'b0;
  localparam logic       PPM_WAKE_CLK    = 1'b0;
  localparam logic [2:0] PPM_PM_VERSION  = 3'h3;
  localparam logic [15:0] PPM_CAP_WORD = {PPM_WAKE_STATES, PPM_MID_LOW,
    PPM_MID_HIGH, PPM_AUX_CURRENT, PPM_DSI, PPM_CAP_RSVD, PPM_WAKE_CLK,
    PPM_PM_VERSION};

  // control/status bit positions
  localparam int PPM_CSR_PEND_BIT = 15;
  localparam int PPM_CSR_EN_BIT   = 8;
  localparam int PPM_CSR_LVL_LSB  = 0;

  // power level codes
  localparam logic [1:0] PPM_LVL_D0    = 2'h0;
  localparam logic [1:0] PPM_LVL_D1    = 2'h1;
  localparam logic [1:0] PPM_LVL_D2    = 2'h2;
  localparam logic [1:0] PPM_LVL_D3HOT = 2'h3;

  // reset values
  localparam logic [1:0] PPM_LVL_RST  = 2'h0;
  localparam logic       PPM_PEND_RST = 1'b0;
  localparam logic       PPM_EN_RST   = 1'b0;

  // pin synchroniser depth
  localparam int PPM_SYNC_STAGES = 2;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } ppm_cfg_req_s;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } ppm_cfg_rsp_s;

  typedef enum {
    PPM_ST_D0_UNINIT,
    PPM_ST_D0_ACTIVE,
    PPM_ST_D3_HOT,
    PPM_ST_D3_COLD
  } ppm_state_e;

endpackage

// File: core/ppm_power_mgmt.sv
// power management capability of a pci target function
`timescale 1ns/1ps

// How it works
// - capabilities bits 15:11 read 11000b, wake only from D3hot and D3cold.
// - capabilities bit 10 reads zero, no D2 state.
// - capabilities bit 9 reads zero, no D1 state.
// - capabilities bits 8:6 read 111b, 375mA auxiliary current.
// - capabilities bit 5 reads zero, no special init after D3.
// - capabilities bit 3 reads zero, wake needs no bus clock.
// - capabilities bits 2:0 read 011b, interface revision 1.2.
// - wake pending bit sets on any wake condition, enabled or not.
// - writing one clears wake pending and stops the wake pin unless a wake condition stands; zero ignored.
// - wake pending survives ordinary resets; only auxiliary reset clears it.
// - wake enable zero means the wake pin is never driven.
// - wake enable survives ordinary resets; only auxiliary reset clears it.
// - data scale and data select fields always read zero.
// - no-soft-reset bit always reads zero.
// - control/status bits 7:4 and 2 always read zero.
// - bits 1:0 hold the last D0 or D3hot power level written by software; D1 and D2 codes are ignored.
// - only D0, D3hot and D3cold are supported.
// - from D3hot a write of the D0 code returns to D0.
// - with only auxiliary power, a wake event drives the wake pin if wake enable is set.
// - uninitialised D0 and active D0 are kept apart.
// - wake request input is the wake event source.
// - a power level indication output is driven for line transceivers.
module ppm_power_mgmt #(
  parameter int SYNC_STAGES = ppm_pkg::PPM_SYNC_STAGES
) (
  // clock and resets
  input  wire logic                 sys_clk,
  input  wire logic                 resetn,
  input  wire logic                 aux_resetn,
  // configuration access
  input  wire ppm_pkg::ppm_cfg_req_s cfg_req,
  output      ppm_pkg::ppm_cfg_rsp_s cfg_rsp_q,
  // pins
  input  wire logic                 wake_request_in,
  input  wire logic                 main_power_ok,
  output      logic                 wake_n_o_q,
  output      logic                 wake_n_oe_q,
  output      logic                 power_level_indicator_out_q,
  // state view
  output      ppm_pkg::ppm_state_e   state_q
);
  import ppm_pkg::*;

  if (SYNC_STAGES < 2) begin : g_bad_sync
    $error("SYNC_STAGES must be at least 2");
  end

  // pin synchronisers
  logic [SYNC_STAGES-1:0] wake_sync_q;
  logic [SYNC_STAGES-1:0] wake_sync_d;
  logic [SYNC_STAGES-1:0] pwr_sync_q;
  logic [SYNC_STAGES-1:0] pwr_sync_d;
  logic                   wake_req_s;
  logic                   main_pwr_s;

  always_comb begin
    wake_sync_d = {wake_sync_q[SYNC_STAGES-2:0], wake_request_in};
    pwr_sync_d  = {pwr_sync_q[SYNC_STAGES-2:0], main_power_ok};
  end

  always_ff @(posedge sys_clk) begin
    if (!aux_resetn) begin
      wake_sync_q <= '0;
      pwr_sync_q  <= '0;
    end else begin
      wake_sync_q <= wake_sync_d;
      pwr_sync_q  <= pwr_sync_d;
    end
  end

  assign wake_req_s = wake_sync_q[SYNC_STAGES-1];
  assign main_pwr_s = pwr_sync_q[SYNC_STAGES-1];

  // decode of a write to the control/status word
  logic       csr_wr;
  logic       wr_lo;
  logic       wr_hi;
  logic [1:0] wr_lvl;

  always_comb begin
    // a request counts only outside ordinary reset
    csr_wr = resetn && cfg_req.req && cfg_req.we &&
             (cfg_req.addr == PPM_CSR_OFS);
    wr_lo  = csr_wr && cfg_req.be[0];
    wr_hi  = csr_wr && cfg_req.be[1];
    wr_lvl = cfg_req.wdata[PPM_CSR_LVL_LSB +: 2];
  end

  // sticky wake bits on auxiliary reset
  logic pend_q;
  logic pend_d;
  logic en_q;
  logic en_d;
  logic wake_cond;

  always_comb begin
    // wake counts in D3hot or when main power is gone
    wake_cond = wake_req_s &&
                (state_q == PPM_ST_D3_HOT || !main_pwr_s);
    pend_d = pend_q;
    if (wr_hi && cfg_req.wdata[PPM_CSR_PEND_BIT]) begin
      pend_d = 1'b0;
    end
    if (wake_cond) begin
      pend_d = 1'b1;
    end
    en_d = en_q;
    if (wr_hi) begin
      en_d = cfg_req.wdata[PPM_CSR_EN_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!aux_resetn) begin
      pend_q <= PPM_PEND_RST;
      en_q   <= PPM_EN_RST;
    end else begin
      pend_q <= pend_d;
      en_q   <= en_d;
    end
  end

  // power level field and function state
  logic [1:0] lvl_q;
  logic [1:0] lvl_d;
  ppm_state_e state_d;

  always_comb begin
    lvl_d   = lvl_q;
    state_d = state_q;
    if (wr_lo && (wr_lvl == PPM_LVL_D0 || wr_lvl == PPM_LVL_D3HOT)) begin
      lvl_d = wr_lvl;
    end
    unique case (state_q)
      PPM_ST_D0_UNINIT: begin
        if (cfg_req.req && cfg_req.we) begin
          state_d = PPM_ST_D0_ACTIVE;
        end
      end
      PPM_ST_D0_ACTIVE: begin
        if (lvl_d == PPM_LVL_D3HOT) begin
          state_d = PPM_ST_D3_HOT;
        end
      end
      PPM_ST_D3_HOT: begin
        if (lvl_d == PPM_LVL_D0) begin
          state_d = PPM_ST_D0_ACTIVE;
        end
      end
      PPM_ST_D3_COLD: begin
        state_d = PPM_ST_D3_COLD;
      end
    endcase
    if (!main_pwr_s) begin
      state_d = PPM_ST_D3_COLD;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      lvl_q   <= PPM_LVL_RST;
      state_q <= PPM_ST_D0_UNINIT;
    end else begin
      lvl_q   <= lvl_d;
      state_q <= state_d;
    end
  end

  // read data and pin outputs
  logic [15:0]  csr_word;
  ppm_cfg_rsp_s rsp_d;
  logic         drive_d;
  logic         ind_d;

  always_comb begin
    csr_word = '0;
    csr_word[PPM_CSR_PEND_BIT] = pend_q;
    csr_word[PPM_CSR_EN_BIT]   = en_q;
    csr_word[PPM_CSR_LVL_LSB +: 2] = lvl_q;
    rsp_d.ack   = cfg_req.req;
    rsp_d.rdata = '0;
    if (cfg_req.req && !cfg_req.we) begin
      if (cfg_req.addr == PPM_CAP_OFS) begin
        rsp_d.rdata = {PPM_CAP_WORD, PPM_NEXT_PTR, PPM_CAP_ID};
      end else if (cfg_req.addr == PPM_CSR_OFS) begin
        rsp_d.rdata = {16'h0000, csr_word};
      end
    end
    drive_d = pend_q && en_q;
    ind_d   = (state_d == PPM_ST_D3_HOT) ||
              (state_d == PPM_ST_D3_COLD);
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cfg_rsp_q <= '0;
    end else begin
      cfg_rsp_q <= rsp_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!aux_resetn) begin
      wake_n_o_q                  <= 1'b0;
      wake_n_oe_q                 <= 1'b0;
      power_level_indicator_out_q <= 1'b0;
    end else begin
      wake_n_o_q                  <= 1'b0;
      wake_n_oe_q                 <= drive_d;
      power_level_indicator_out_q <= ind_d;
    end
  end

  // checks
  sequence cap_read_s;
    cfg_req.req && !cfg_req.we && cfg_req.addr == PPM_CAP_OFS;
  endsequence

  sequence csr_read_s;
    cfg_req.req && !cfg_req.we && cfg_req.addr == PPM_CSR_OFS;
  endsequence

  sequence one_clear_s;
    wr_hi && cfg_req.wdata[PPM_CSR_PEND_BIT] && !wake_cond;
  endsequence

  sequence cold_wake_s;
    !main_pwr_s && wake_req_s && en_q && !wr_hi;
  endsequence

  cap_word_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    cap_read_s |=> cfg_rsp_q.ack &&
      cfg_rsp_q.rdata == 32'hc1c3_0001)
    else $error("capabilities word wrong");

  cap_zero_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    cap_read_s |=> cfg_rsp_q.rdata[26:25] == 2'h0 &&
      !cfg_rsp_q.rdata[21] && !cfg_rsp_q.rdata[19])
    else $error("capability zero bits set");

  csr_zero_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    csr_read_s |=> (cfg_rsp_q.rdata & 32'hffff_7efc) == 32'h0)
    else $error("reserved control bits not zero");

  csr_fields_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    csr_read_s |=> cfg_rsp_q.ack && cfg_rsp_q.rdata[15] == $past(pend_q) &&
      cfg_rsp_q.rdata[8] == $past(en_q) &&
      cfg_rsp_q.rdata[1:0] == $past(lvl_q))
    else $error("control word fields read wrong");

  wake_sets_a: assert property (
    @(posedge sys_clk) disable iff (!aux_resetn)
    wake_cond |=> pend_q)
    else $error("wake condition did not set pending");

  pend_source_a: assert property (
    @(posedge sys_clk) disable iff (!aux_resetn)
    !pend_q && !wake_cond |=> !pend_q)
    else $error("pending set without a wake event");

  pend_clear_a: assert property (
    @(posedge sys_clk) disable iff (!aux_resetn)
    one_clear_s |=> !pend_q ##1 !wake_n_oe_q)
    else $error("write one did not clear pending");

  pend_hold_a: assert property (
    @(posedge sys_clk) disable iff (!aux_resetn)
    wr_hi && !cfg_req.wdata[PPM_CSR_PEND_BIT] && pend_q |=> pend_q)
    else $error("write zero changed pending");

  pend_sticky_a: assert property (
    @(posedge sys_clk) disable iff (!aux_resetn)
    !resetn && pend_q |=> pend_q)
    else $error("pending lost on ordinary reset");

  en_sticky_a: assert property (
    @(posedge sys_clk) disable iff (!aux_resetn)
    !resetn && !wr_hi && en_q |=> en_q)
    else $error("enable lost on ordinary reset");

  en_write_a: assert property (
    @(posedge sys_clk) disable iff (!aux_resetn)
    wr_hi |=> en_q == $past(cfg_req.wdata[PPM_CSR_EN_BIT]))
    else $error("enable bit not written");

  pin_gate_a: assert property (
    @(posedge sys_clk) disable iff (!aux_resetn)
    ##1 wake_n_oe_q == ($past(pend_q) && $past(en_q)))
    else $error("wake pin not gated by pending and enable");

  cold_wake_a: assert property (
    @(posedge sys_clk) disable iff (!aux_resetn)
    cold_wake_s |=> pend_q ##1 wake_n_oe_q)
    else $error("wake not signalled without main power");

  lvl_write_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    wr_lo && (wr_lvl == PPM_LVL_D0 || wr_lvl == PPM_LVL_D3HOT)
    |=> lvl_q == $past(wr_lvl))
    else $error("power level not written");

  lvl_ignore_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    wr_lo && (wr_lvl == PPM_LVL_D1 || wr_lvl == PPM_LVL_D2)
    |=> $stable(lvl_q))
    else $error("D1 or D2 code was accepted");

  no_mid_level_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    lvl_q != PPM_LVL_D1 && lvl_q != PPM_LVL_D2)
    else $error("unsupported power level held");

  hot_to_d0_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    state_q == PPM_ST_D3_HOT && wr_lo && wr_lvl == PPM_LVL_D0 && main_pwr_s
    |=> state_q == PPM_ST_D0_ACTIVE && lvl_q == PPM_LVL_D0)
    else $error("D0 write did not leave D3hot");

  reset_uninit_a: assert property (
    @(posedge sys_clk) disable iff (!aux_resetn)
    !resetn |=> state_q == PPM_ST_D0_UNINIT && lvl_q == PPM_LVL_D0)
    else $error("ordinary reset did not give uninitialised D0");

  first_write_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    state_q == PPM_ST_D0_UNINIT && cfg_req.req && cfg_req.we && main_pwr_s
    |=> state_q == PPM_ST_D0_ACTIVE)
    else $error("first write did not activate D0");

  uninit_hold_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    state_q == PPM_ST_D0_UNINIT && !(cfg_req.req && cfg_req.we) && main_pwr_s
    |=> state_q == PPM_ST_D0_UNINIT)
    else $error("uninitialised D0 left without a write");

  cold_entry_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    !main_pwr_s |=> state_q == PPM_ST_D3_COLD)
    else $error("main power lost but not in D3cold");

  indicator_a: assert property (
    @(posedge sys_clk) disable iff (!aux_resetn)
    resetn && (state_q == PPM_ST_D3_HOT || state_q == PPM_ST_D3_COLD)
    |-> power_level_indicator_out_q)
    else $error("indicator low while in a D3 state");

  indicator_low_a: assert property (
    @(posedge sys_clk) disable iff (!aux_resetn)
    $past(resetn) && (state_q == PPM_ST_D0_UNINIT ||
      state_q == PPM_ST_D0_ACTIVE) |-> !power_level_indicator_out_q)
    else $error("indicator high while in D0");

endmodule // ppm_power_mgmt

// File: sim/ppm_host_model.sv
// host side model: config cycles, main power and ordinary reset
`timescale 1ns/1ps
module ppm_host_model (
  // clock
  input  wire logic                  sys_clk,
  // config port
  output      ppm_pkg::ppm_cfg_req_s cfg_req,
  input  wire ppm_pkg::ppm_cfg_rsp_s cfg_rsp_q,
  // power and reset
  output      logic                  resetn,
  output      logic                  main_power_ok,
  // wake pin
  input  wire logic                  wake_n_o_q,
  input  wire logic                  wake_n_oe_q,
  output      logic                  wake_n
);
  import ppm_pkg::*;
  // open-drain wire with board pull-up
  assign wake_n = wake_n_oe_q ? wake_n_o_q : 1'b1;
  initial begin
    cfg_req = '0;
    resetn = 1'b0;
    main_power_ok = 1'b1;
  end
  // one config cycle; gives up after four cycles without ack
  task automatic access(input logic we, input logic [7:0] addr,
      input logic [31:0] wdata, output logic [31:0] rdata, output bit ok);
    ppm_cfg_req_s idle;
    ok = 1'b0;
    rdata = '0;
    @(posedge sys_clk) #1;
    cfg_req = '{req: 1'b1, we: we, addr: addr, be: 4'hf, wdata: wdata};
    @(posedge sys_clk) #1;
    // released fields do not keep their last value
    idle = ~cfg_req;
    idle.req = 1'b0;
    cfg_req = idle;
    for (int i = 0; i < 4 && !ok; i++) begin
      if (cfg_rsp_q.ack === 1'b1) begin
        rdata = cfg_rsp_q.rdata;
        ok = 1'b1;
      end else begin
        @(posedge sys_clk) #1;
      end
    end
  endtask
  // main power back, then reset held n cycles
  task automatic restore(input int n);
    main_power_ok = 1'b1;
    resetn = 1'b0;
    repeat (n) @(posedge sys_clk);
    #1;
    resetn = 1'b1;
  endtask
  task automatic cut_power();
    main_power_ok = 1'b0;
  endtask
endmodule // ppm_host_model

// File: sim/testbench.sv
// self-checking bench for the power management capability
`timescale 1ns/1ps
module testbench;
  import ppm_pkg::*;
  typedef struct {
    logic        we;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [31:0] exp;
  } ppm_row_s;
  logic         sys_clk = 1'b0;
  logic         resetn;
  logic         aux_resetn = 1'b0;
  logic         wake_request_in = 1'b0;
  logic         main_power_ok;
  logic         wake_n_o_q;
  logic         wake_n_oe_q;
  logic         power_level_indicator_out_q;
  logic         wake_n;
  ppm_cfg_req_s cfg_req;
  ppm_cfg_rsp_s cfg_rsp_q;
  ppm_state_e   state_q;
  logic [31:0]  rd;
  bit           ok;
  int           num_errors = 0;
  int           total_checks = 0;
  ppm_row_s     rows [12] = '{
    '{1'b0, 8'h40, 32'h0, 32'hc1c3_0001},
    '{1'b0, 8'h44, 32'h0, 32'h0},
    '{1'b1, 8'h40, 32'hffff_ffff, 32'h0},
    '{1'b0, 8'h40, 32'h0, 32'hc1c3_0001},
    '{1'b1, 8'h44, 32'h0000_7f7f, 32'h0},
    '{1'b0, 8'h44, 32'h0, 32'h0000_0103},
    '{1'b1, 8'h44, 32'h0000_0101, 32'h0},
    '{1'b0, 8'h44, 32'h0, 32'h0000_0103},
    '{1'b1, 8'h44, 32'h0000_0102, 32'h0},
    '{1'b0, 8'h44, 32'h0, 32'h0000_0103},
    '{1'b1, 8'h48, 32'hffff_ffff, 32'h0},
    '{1'b0, 8'h48, 32'h0, 32'h0}
  };
  always #5 sys_clk = ~sys_clk;
  ppm_power_mgmt dut (
    .sys_clk                     (sys_clk),
    .resetn                      (resetn),
    .aux_resetn                  (aux_resetn),
    .cfg_req                     (cfg_req),
    .cfg_rsp_q                   (cfg_rsp_q),
    .wake_request_in             (wake_request_in),
    .main_power_ok               (main_power_ok),
    .wake_n_o_q                  (wake_n_o_q),
    .wake_n_oe_q                 (wake_n_oe_q),
    .power_level_indicator_out_q (power_level_indicator_out_q),
    .state_q                     (state_q)
  );
  ppm_host_model host (
    .sys_clk       (sys_clk),
    .cfg_req       (cfg_req),
    .cfg_rsp_q     (cfg_rsp_q),
    .resetn        (resetn),
    .main_power_ok (main_power_ok),
    .wake_n_o_q    (wake_n_o_q),
    .wake_n_oe_q   (wake_n_oe_q),
    .wake_n        (wake_n)
  );
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic cfg(input logic we, input logic [7:0] a,
      input logic [31:0] d);
    host.access(we, a, d, rd, ok);
    if (!ok) begin
      num_errors++;
      $display("unexpected at %0t: no ack", $time);
      summarize();
    end
  endtask
  // bounded wait for the pin enable, then enable and wire level
  task automatic wait_oe(input logic v);
    for (int n = 0; n < 8 && wake_n_oe_q !== v; n++) begin
      @(posedge sys_clk) #1;
    end
    check({30'h0, wake_n_oe_q, wake_n}, {30'h0, v, ~v});
  endtask
  initial begin
    // aux reset released first so the power sync settles
    fork
      host.restore(8);
      begin
        repeat (4) @(posedge sys_clk);
        #1;
        aux_resetn = 1'b1;
      end
    join
    foreach (rows[i]) begin
      cfg(rows[i].we, rows[i].addr, rows[i].wdata);
      if (!rows[i].we) check(rd, rows[i].exp);
    end
    $display("test table done");
    check(32'(state_q), 32'(PPM_ST_D3_HOT));
    check({31'h0, power_level_indicator_out_q}, 32'h1);
    wake_request_in = 1'b1;
    wait_oe(1'b1);
    wake_request_in = 1'b0;
    repeat (4) @(posedge sys_clk) #1;
    cfg(1'b0, 8'h44, 32'h0);
    check(rd, 32'h0000_8103);
    $display("test wake in d3hot done");
    host.restore(2);
    check(32'(state_q), 32'(PPM_ST_D0_UNINIT));
    cfg(1'b0, 8'h44, 32'h0);
    check(rd, 32'h0000_8100);
    cfg(1'b1, 8'h44, 32'h0000_0100);
    check(32'(state_q), 32'(PPM_ST_D0_ACTIVE));
    cfg(1'b0, 8'h44, 32'h0);
    check(rd, 32'h0000_8100);
    cfg(1'b1, 8'h44, 32'h0000_8103);
    wait_oe(1'b0);
    cfg(1'b0, 8'h44, 32'h0);
    check(rd, 32'h0000_0103);
    $display("test sticky and clear done");
    cfg(1'b1, 8'h44, 32'h0000_0003);
    wake_request_in = 1'b1;
    repeat (6) @(posedge sys_clk) #1;
    wake_request_in = 1'b0;
    repeat (4) @(posedge sys_clk) #1;
    check({30'h0, wake_n_oe_q, wake_n}, 32'h1);
    cfg(1'b0, 8'h44, 32'h0);
    check(rd, 32'h0000_8003);
    cfg(1'b1, 8'h44, 32'h0000_8000);
    check(32'(state_q), 32'(PPM_ST_D0_ACTIVE));
    check({31'h0, power_level_indicator_out_q}, 32'h0);
    $display("test wake disabled done");
    cfg(1'b1, 8'h44, 32'h0000_0100);
    host.cut_power();
    for (int n = 0; n < 8 && state_q !== PPM_ST_D3_COLD; n++) begin
      @(posedge sys_clk) #1;
    end
    check(32'(state_q), 32'(PPM_ST_D3_COLD));
    wake_request_in = 1'b1;
    wait_oe(1'b1);
    // clear while the wake event still stands: the set wins
    cfg(1'b1, 8'h44, 32'h0000_8100);
    cfg(1'b0, 8'h44, 32'h0);
    check(rd, 32'h0000_8100);
    check({31'h0, power_level_indicator_out_q}, 32'h1);
    wake_request_in = 1'b0;
    host.restore(4);
    check(32'(state_q), 32'(PPM_ST_D0_UNINIT));
    $display("test wake in d3cold done");
    fork
      host.restore(6);
      begin
        aux_resetn = 1'b0;
        repeat (4) @(posedge sys_clk);
        #1;
        aux_resetn = 1'b1;
      end
    join
    cfg(1'b0, 8'h44, 32'h0);
    check(rd, 32'h0);
    wait_oe(1'b0);
    $display("test aux reset done");
    summarize();
  end
endmodule // testbench
